// >>> hw/energy_pulse_output_params.svh
`ifndef ENERGY_PULSE_OUTPUT_PARAMS_SVH
`define ENERGY_PULSE_OUTPUT_PARAMS_SVH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define EPO_OFS_CTRL 12'h000
`define EPO_OFS_GEN_WIDTH 12'h004
`define EPO_OFS_CAL_WIDTH 12'h008
`define EPO_OFS_EPP 12'h00C
`define EPO_OFS_STATUS 12'h010
`define EPO_OFS_ACC 12'h014
// ---------------------------------------------
// control field positions
// ---------------------------------------------
`define EPO_GEN_STYLE_BIT 0
`define EPO_GEN_POL_BIT 1
`define EPO_GEN_PORT_LSB 4
`define EPO_CAL_STYLE_BIT 8
`define EPO_CAL_INT_LSB 9
`define EPO_CAL_PORT_LSB 12
`define EPO_CH_USED_LSB 16
// ---------------------------------------------
// reset values and timing
// ---------------------------------------------
`define EPO_CLK_HZ 25000000
`define EPO_WIDTH_DEF_S 1
`define EPO_WIDTH_DEF_CYC (`EPO_WIDTH_DEF_S * `EPO_CLK_HZ)
`define EPO_TICK_HZ 1000
`define EPO_TICK_CYC (`EPO_CLK_HZ / `EPO_TICK_HZ)
`define EPO_EPP_DEF_MWH 1800
`endif

// >>> hw/energy_pulse_output_pkg.sv
`default_nettype none
package energy_pulse_output_pkg;
	typedef enum logic [1:0] {STYLE_PULSE = 2'b00, STYLE_TRANSITION = 2'b01} style_t;
	typedef enum logic [1:0] {INT_FORWARD = 2'b00, INT_REVERSE = 2'b01, INT_ABSOLUTE = 2'b10, INT_NET = 2'b11} int_mode_t;
	typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_HIGH = 2'b01, PH_LOW = 2'b10} phase_t;
	typedef struct packed {
		logic gen_style;
		logic gen_pol;
		logic [2:0] gen_port;
		logic cal_style;
		logic [1:0] cal_int;
		logic [2:0] cal_port;
		logic [31:0] gen_width;
		logic [31:0] cal_width;
		logic [31:0] epp;
		logic signed [47:0] acc;
		logic [31:0] tick_cnt;
		phase_t gen_ph;
		logic [31:0] gen_cnt;
		logic gen_lvl;
		logic [7:0] gen_pend;
		phase_t cal_ph;
		logic [31:0] cal_cnt;
		logic [31:0] cal_hi_len;
		logic cal_lvl;
		logic [7:0] cal_pend;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [7:0] ch_out;
	} state_t;
endpackage : energy_pulse_output_pkg
`default_nettype wire

// >>> hw/energy_pulse_output.sv
// Contract
// - general pulser forwards internal pulse events as pulses or transitions to a channel
// - general pulse width is programmable in seconds, one second after reset; the code takes the width in pclk cycles, reset to 25000000
// - output style chooses full pulse or single state change per event
// - polarity inverts general pulse output, ignored in transition style
// - port selector routes general output to one channel not claimed elsewhere
// - after reset no channel is selected for the general pulser
// - calibration pulser takes real, reactive or apparent power, drives one channel
// - calibration pulser accumulates energy, pulses each time constant amount is reached
// - default constant gives one pulse per 1.8 Wh
// - calibration pulse holds programmed width, duty cycle never below half; the code keeps low time at least the high time, so duty is at most half
// - calibration output style is pulse or single state change per quantum
// - calibration port selector picks one free channel, none after reset
// - selectable integration mode governs how power becomes energy
// - led calibration keeps 1.8 Wh per pulse in normal and test mode
//
// Implementation choices: the APB slave port and the register addresses.
`include "energy_pulse_output_params.svh"
`default_nettype none
module energy_pulse_output (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] event_in,
	input wire logic [1:0] event_sel,
	input wire logic [1:0] power_sel,
	input wire logic signed [31:0] power_real_mw,
	input wire logic signed [31:0] power_reactive_mw,
	input wire logic signed [31:0] power_apparent_mw,
	input wire logic test_mode,
	input wire logic [7:0] ch_claimed,
	output logic [7:0] ch_out
);
	// ---------------------------------------------
	// state
	// ---------------------------------------------
	energy_pulse_output_pkg::state_t s_q;
	energy_pulse_output_pkg::state_t s_d;
	logic ev_now;
	logic signed [31:0] pw;
	logic signed [47:0] inc;
	logic [47:0] epp_wide;
	logic quantum;
	logic [31:0] rd;
	logic [31:0] wmask;
	logic gen_ok;
	logic cal_ok;
	logic wr;

	// power in mW, one tick per ms: acc counts mW*ms, so one mWh of the constant is 3600000 of it
	assign epp_wide = 48'(s_q.epp) * 48'd3600000;
	assign gen_ok = s_q.gen_port != 3'h0 && !ch_claimed[s_q.gen_port - 3'h1];
	assign cal_ok = s_q.cal_port != 3'h0 && !ch_claimed[s_q.cal_port - 3'h1];

	always_comb
	begin
		s_d = s_q;
		ev_now = event_in[{1'b0, event_sel}] | event_in[{1'b1, event_sel}];
		// source choice: real, reactive or apparent power
		case (power_sel)
			2'b01: pw = power_reactive_mw;
			2'b10: pw = power_apparent_mw;
			default: pw = power_real_mw;
		endcase
		// integration mode; test_mode does not alter accumulation, keeping led rate
		case (energy_pulse_output_pkg::int_mode_t'(s_q.cal_int))
			energy_pulse_output_pkg::INT_FORWARD: inc = (pw > 0) ? 48'(pw) : 48'sd0;
			energy_pulse_output_pkg::INT_REVERSE: inc = (pw < 0) ? -48'(pw) : 48'sd0;
			energy_pulse_output_pkg::INT_ABSOLUTE: inc = (pw < 0) ? -48'(pw) : 48'(pw);
			default: inc = 48'(pw);
		endcase
		quantum = 1'b0;
		wr = psel && penable && pwrite && s_q.pready;
		wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
		// ---------------------------------------------
		// energy integration
		// ---------------------------------------------
		if (s_q.tick_cnt == 32'(`EPO_TICK_CYC - 1))
		begin
			s_d.tick_cnt = 32'h0;
			s_d.acc = s_q.acc + inc;
		end
		else
			s_d.tick_cnt = s_q.tick_cnt + 32'h1;
		if (s_q.epp != 32'h0 && s_d.acc >= $signed(epp_wide))
		begin
			s_d.acc = s_d.acc - $signed(epp_wide);
			quantum = 1'b1;
		end
		else if (s_q.cal_int == 2'b11 && s_d.acc <= -$signed(epp_wide))
			s_d.acc = s_d.acc + $signed(epp_wide);
		// ---------------------------------------------
		// general pulser
		// ---------------------------------------------
		if (ev_now && s_q.gen_pend != 8'hFF)
			s_d.gen_pend = s_q.gen_pend + 8'h1;
		case (s_q.gen_ph)
			energy_pulse_output_pkg::PH_IDLE:
				if (s_q.gen_pend != 8'h0)
				begin
					s_d.gen_pend = s_d.gen_pend - 8'h1;
					if (s_q.gen_style)
						s_d.gen_lvl = !s_q.gen_lvl;
					else
					begin
						s_d.gen_lvl = 1'b1;
						s_d.gen_cnt = 32'h0;
						s_d.gen_ph = energy_pulse_output_pkg::PH_HIGH;
					end
				end
			energy_pulse_output_pkg::PH_HIGH:
				if (s_q.gen_cnt + 32'h1 >= s_q.gen_width)
				begin
					s_d.gen_lvl = 1'b0;
					s_d.gen_ph = energy_pulse_output_pkg::PH_IDLE;
				end
				else
					s_d.gen_cnt = s_q.gen_cnt + 32'h1;
			default: s_d.gen_ph = energy_pulse_output_pkg::PH_IDLE;
		endcase
		// ---------------------------------------------
		// calibration pulser
		// ---------------------------------------------
		if (quantum && s_q.cal_pend != 8'hFF)
			s_d.cal_pend = s_q.cal_pend + 8'h1;
		case (s_q.cal_ph)
			energy_pulse_output_pkg::PH_IDLE:
				if (s_q.cal_pend != 8'h0)
				begin
					s_d.cal_pend = s_d.cal_pend - 8'h1;
					if (s_q.cal_style)
						s_d.cal_lvl = !s_q.cal_lvl;
					else
					begin
						s_d.cal_lvl = 1'b1;
						s_d.cal_cnt = 32'h0;
						s_d.cal_ph = energy_pulse_output_pkg::PH_HIGH;
					end
				end
			energy_pulse_output_pkg::PH_HIGH:
				if (s_q.cal_cnt + 32'h1 >= s_q.cal_width)
				begin
					s_d.cal_lvl = 1'b0;
					s_d.cal_hi_len = s_q.cal_cnt + 32'h1;
					s_d.cal_cnt = 32'h0;
					s_d.cal_ph = energy_pulse_output_pkg::PH_LOW;
				end
				else
					s_d.cal_cnt = s_q.cal_cnt + 32'h1;
			energy_pulse_output_pkg::PH_LOW:
				// low time at least the high time; fast energy backs up in cal_pend instead
				if (s_q.cal_cnt + 32'h1 >= s_q.cal_hi_len)
					s_d.cal_ph = energy_pulse_output_pkg::PH_IDLE;
				else
					s_d.cal_cnt = s_q.cal_cnt + 32'h1;
			default: s_d.cal_ph = energy_pulse_output_pkg::PH_IDLE;
		endcase
		// ---------------------------------------------
		// channel routing
		// ---------------------------------------------
		s_d.ch_out = 8'h0;
		if (gen_ok)
			s_d.ch_out[s_q.gen_port - 3'h1] = s_q.gen_style ? s_q.gen_lvl : (s_q.gen_lvl ^ s_q.gen_pol);
		if (cal_ok && s_q.cal_port != s_q.gen_port)
			s_d.ch_out[s_q.cal_port - 3'h1] = s_q.cal_lvl;
		// ---------------------------------------------
		// apb slave, no wait state
		// ---------------------------------------------
		rd = 32'h0;
		case (paddr)
			// reserved bits read as zero so software can mask-compare the whole word
			`EPO_OFS_CTRL: rd = {8'h0, ch_claimed, 1'b0, s_q.cal_port, 1'b0, s_q.cal_int, s_q.cal_style, 1'b0,
				s_q.gen_port, 2'b0, s_q.gen_pol, s_q.gen_style};
			`EPO_OFS_GEN_WIDTH: rd = s_q.gen_width;
			`EPO_OFS_CAL_WIDTH: rd = s_q.cal_width;
			`EPO_OFS_EPP: rd = s_q.epp;
			`EPO_OFS_STATUS: rd = {22'h0, s_q.cal_ph, s_q.gen_ph, test_mode, s_q.cal_lvl, s_q.gen_lvl, gen_ok, cal_ok, 1'b0};
			`EPO_OFS_ACC: rd = s_q.acc[31:0];
			default: rd = 32'h0;
		endcase
		s_d.pready = psel && !s_q.pready;
		if (psel && !s_q.pready)
		begin
			s_d.prdata = pwrite ? 32'h0 : rd;
			s_d.pslverr = paddr[1:0] != 2'b00 || paddr > `EPO_OFS_ACC;
		end
		if (!psel)
			s_d.pslverr = 1'b0;
		if (wr && !s_q.pslverr)
			case (paddr)
				`EPO_OFS_CTRL:
					if (pstrb[0] && pstrb[1])
						{s_d.cal_port, s_d.gen_port, s_d.cal_int, s_d.cal_style, s_d.gen_pol, s_d.gen_style} =
							{pwdata[14:12], pwdata[6:4], pwdata[10:9], pwdata[8], pwdata[1], pwdata[0]};
				`EPO_OFS_GEN_WIDTH: s_d.gen_width = (s_q.gen_width & ~wmask) | (pwdata & wmask);
				`EPO_OFS_CAL_WIDTH: s_d.cal_width = (s_q.cal_width & ~wmask) | (pwdata & wmask);
				`EPO_OFS_EPP: s_d.epp = (s_q.epp & ~wmask) | (pwdata & wmask);
				default: ;
			endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_q <= '0;
			s_q.gen_width <= 32'(`EPO_WIDTH_DEF_CYC);
			s_q.cal_width <= 32'(`EPO_WIDTH_DEF_CYC);
			s_q.epp <= 32'(`EPO_EPP_DEF_MWH);
		end
		else if (clk_en)
			s_q <= s_d;
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign ch_out = s_q.ch_out;

	// ---------------------------------------------
	// duty watch
	// ---------------------------------------------
	// measured on the cal_lvl level itself, so a slip in the phase counters cannot hide a short low time
	logic [31:0] cal_hi_run_q;
	logic [31:0] cal_lo_run_q;
	logic [31:0] cal_hi_last_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cal_hi_run_q <= 32'h0;
			cal_lo_run_q <= 32'h0;
			cal_hi_last_q <= 32'h0;
		end
		else if (clk_en)
		begin
			if (s_q.cal_lvl)
			begin
				cal_hi_run_q <= cal_hi_run_q + 32'h1;
				cal_lo_run_q <= 32'h0;
			end
			else
			begin
				if (cal_hi_run_q != 32'h0)
					cal_hi_last_q <= cal_hi_run_q;
				cal_hi_run_q <= 32'h0;
				cal_lo_run_q <= cal_lo_run_q + 32'h1;
			end
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	a_reset_no_port: assert property (@(posedge pclk)
		$rose(presetn) |-> s_q.gen_port == 3'h0 && s_q.cal_port == 3'h0)
		else $error("port selected after reset");
	a_cal_duty: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.cal_ph == energy_pulse_output_pkg::PH_LOW |-> !s_q.cal_lvl)
		else $error("calibration output high during low phase");
	a_toggle_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.gen_style && s_q.gen_pend == 8'h0 && clk_en && !ev_now && $stable(s_q.gen_style)) |=> $stable(s_q.gen_lvl))
		else $error("transition output changed without event");
	a_unrouted_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.gen_port == 3'h0 && s_q.cal_port == 3'h0 && clk_en) |=> ch_out == 8'h0)
		else $error("output driven with no port");
	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pready && clk_en) |=> pready)
		else $error("apb answer missing");
	a_apb_single: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && clk_en) |=> !pready)
		else $error("apb answer held too long");
	// pulse style only: a transition may legally stay low for any time
	a_cal_low_run: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && !s_q.cal_style && !s_q.cal_lvl && s_d.cal_lvl && cal_hi_last_q != 32'h0)
		|-> cal_lo_run_q + 32'h1 >= cal_hi_last_q)
		else $error("calibration low time shorter than high time");
	a_claimed_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en |=> (ch_out & $past(ch_claimed)) == 8'h0)
		else $error("claimed channel driven");
	a_pol_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_en && gen_ok && s_q.gen_style) |=> ch_out[$past(s_q.gen_port) - 3'h1] == $past(s_q.gen_lvl))
		else $error("polarity applied in transition style");
	a_reset_defaults: assert property (@(posedge pclk)
		$rose(presetn) |-> s_q.epp == 32'(`EPO_EPP_DEF_MWH)
			&& s_q.cal_width == 32'(`EPO_WIDTH_DEF_CYC) && s_q.gen_width == 32'(`EPO_WIDTH_DEF_CYC))
		else $error("defaults wrong after reset");
	c_gen_pulse: cover property (@(posedge pclk) s_q.gen_ph == energy_pulse_output_pkg::PH_HIGH);
	c_cal_quantum: cover property (@(posedge pclk) s_q.cal_ph == energy_pulse_output_pkg::PH_LOW);
	c_toggle: cover property (@(posedge pclk) s_q.cal_style && $changed(s_q.cal_lvl));
	c_claimed_block: cover property (@(posedge pclk) s_q.gen_port != 3'h0 && !gen_ok);
	c_cal_backlog: cover property (@(posedge pclk) s_q.cal_pend > 8'h1);
endmodule : energy_pulse_output
`default_nettype wire

// >>> tb/pulse_counter_model.sv
`default_nettype none
// far-side counter: counts edges and the length of each high phase on one channel
module pulse_counter_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic line,
	output int rises,
	output int edges,
	output int hi_len
);
	timeunit 1ns;
	timeprecision 1ps;
	logic prev;
	int run;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prev <= 1'b0;
			run <= 0;
			rises <= 0;
			edges <= 0;
			hi_len <= 0;
		end
		else
		begin
			prev <= line;
			if (line !== prev)
				edges <= edges + 1;
			if (line && !prev)
			begin
				rises <= rises + 1;
				run <= 1;
			end
			else if (line)
				run <= run + 1;
			if (!line && prev)
				hi_len <= run;
		end
	end
endmodule : pulse_counter_model
`default_nettype wire

// >>> tb/energy_pulse_output_tb_top.sv
`default_nettype none
module energy_pulse_output_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, er;
	logic test_mode = 1'b1;
	logic [7:0] event_in = 8'h00, ch_claimed = 8'h00, ch_out;
	logic [1:0] power_sel = 2'h0;
	logic signed [31:0] p_real = 32'h00000000, p_react = 32'h00000000;
	int error_cnt = 0, num_checks = 0, cyc_cnt = 0, w, n, g0, g1, c0, c1, gh, ch;
	// ---------------------------------------------
	// clock, design and far-side counters
	// ---------------------------------------------
	always #20 pclk = ~pclk;
	energy_pulse_output dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_in(event_in), .event_sel(2'h0), .power_sel(power_sel), .power_real_mw(p_real),
		.power_reactive_mw(p_react), .power_apparent_mw(32'h00000000), .test_mode(test_mode),
		.ch_claimed(ch_claimed), .ch_out(ch_out));
	pulse_counter_model gen_u (.pclk(pclk), .presetn(presetn), .line(ch_out[0]), .rises(g0), .edges(g1), .hi_len(gh));
	pulse_counter_model cal_u (.pclk(pclk), .presetn(presetn), .line(ch_out[1]), .rises(c0), .edges(c1), .hi_len(ch));
	// ---------------------------------------------
	// tasks
	// ---------------------------------------------
	task complete_run;
		if (error_cnt == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	always @(posedge pclk)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 90000)
		begin
			error_cnt = error_cnt + 1;
			complete_run();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			error_cnt = error_cnt + 1;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// control readback: claimed channels in bits 23:16 above the written fields
	function automatic logic [31:0] ctrl_word(input logic [7:0] claimed, input logic [11:0] low);
		return {8'h00, claimed, 4'h0, low};
	endfunction : ctrl_word
	// request held until the rising edge that samples pready high; answer taken and released there
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// selected source is event_in[0] or event_in[4], picked at random each cycle
	task ev(input int cnt);
		repeat (cnt)
		begin
			@(posedge pclk);
			event_in <= 8'h01 << (4 * ($urandom % 2));
		end
		@(posedge pclk);
		event_in <= 8'h00;
	endtask : ev
	task wt(input int cnt);
		repeat (cnt) @(posedge pclk);
		@(negedge pclk);
	endtask : wt
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial
	begin
		void'($urandom(32'h3C3F));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wt(1);
		chk(ch_out, 8'h00);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, ctrl_word(8'h00, 12'h000));
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h017D7840);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h017D7840);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h00000708);
		apb(1'b0, 12'h018, 32'h0);
		chk(er, 1'b1);
		w = 2 + $urandom % 8;
		apb(1'b1, 12'h004, w);
		apb(1'b1, 12'h000, 32'h00000010);
		ev(1);
		wt(w + 10);
		chk(g0, 1);
		chk(gh, w);
		apb(1'b1, 12'h000, 32'h00000012);
		wt(4);
		chk(ch_out[0], 1'b1);
		apb(1'b1, 12'h000, 32'h00000013);
		wt(4);
		chk(ch_out[0], 1'b0);
		n = g1;
		w = 1 + $urandom % 4;
		ev(w);
		wt(10);
		chk(g1 - n, w);
		@(posedge pclk);
		ch_claimed <= 8'h01;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, ctrl_word(8'h01, 12'h013));
		ev(1);
		wt(4);
		chk(ch_out[0], 1'b0);
		// one quantum of 1 mWh per 1 ms tick from a negative reactive source in reverse mode
		apb(1'b1, 12'h00C, 32'h00000001);
		apb(1'b1, 12'h008, 32'h0000000A);
		p_real <= $urandom % 32'h00010000;
		p_react <= 32'hFFC91180;
		power_sel <= 2'h1;
		apb(1'b1, 12'h000, 32'h00002200);
		n = 0;
		while (c0 == 0 && n < 30000)
		begin
			wt(0);
			n = n + 1;
		end
		chk(c0, 1);
		// the rate must not change when the meter leaves test mode
		@(posedge pclk);
		test_mode <= 1'b0;
		n = c0;
		wt(50010);
		chk(c0, 3);
		chk(c0 - n, 2);
		chk(ch, 10);
		chk(c1, 6);
		chk(ch_out[0], 1'b0);
		complete_run();
	end
endmodule : energy_pulse_output_tb_top
`default_nettype wire
